// file: design/mfg_defs.svh
// Constants of the media/x87 enable and fault gate: query leaves, result bit
// positions, enable-mask layout and reset value.
// Assumes inclusion by bare name from the design files.
`ifndef MFG_DEFS_SVH
`define MFG_DEFS_SVH
`define MFG_LEAF_STD 32'h0000_0001
`define MFG_LEAF_EXT 32'h8000_0001
`define MFG_LEAF_XST 32'h0000_000d
`define MFG_SUB_ZERO 32'h0000_0000
`define MFG_SUB_ONE 32'h0000_0001
`define MFG_EDX_X87 0
`define MFG_EDX_PKINT 23
`define MFG_EDX_FULLSAVE 24
`define MFG_STD_EDX_SSE1 25
`define MFG_STD_EDX_SSE2 26
`define MFG_STD_ECX_SSE3 0
`define MFG_STD_ECX_SSSE3 9
`define MFG_STD_ECX_FMA 12
`define MFG_STD_ECX_SSE41 19
`define MFG_STD_ECX_SSE42 20
`define MFG_STD_ECX_XSAVE 26
`define MFG_STD_ECX_AVX 28
`define MFG_EXT_ECX_SSE4A 6
`define MFG_EXT_ECX_XOP 11
`define MFG_EXT_ECX_FMA4 16
`define MFG_EXT_EDX_PKEXT 22
`define MFG_EXT_EDX_FASTSAVE 25
`define MFG_EXT_EDX_V3DEXT 30
`define MFG_EXT_EDX_V3D 31
`define MFG_XST1_EAX_OPTSAVE 0
`define MFG_XCR_X87 0
`define MFG_XCR_SSE 1
`define MFG_XCR_YMM 2
`define MFG_EXTENDED_FEATURE_ENABLE_MASK_INDEX 32'h0000_0000
`define MFG_EXTENDED_FEATURE_ENABLE_MASK_RST 64'h0000_0000_0000_0001
`endif

// file: design/mfg_pkg.sv
// Types of the media/x87 enable and fault gate.
// Assumes nothing of its surroundings.
package mfg_pkg;
	typedef enum logic [4:0] {
		MFG_G_X87 = 5'h00,
		MFG_G_FPWAIT = 5'h01,
		MFG_G_PKINT = 5'h02,
		MFG_G_PKINT_EXT = 5'h03,
		MFG_G_V3D = 5'h04,
		MFG_G_V3D_EXT = 5'h05,
		MFG_G_SSE1 = 5'h06,
		MFG_G_SSE2 = 5'h07,
		MFG_G_SSE3 = 5'h08,
		MFG_G_SSSE3 = 5'h09,
		MFG_G_SSE41 = 5'h0a,
		MFG_G_SSE42 = 5'h0b,
		MFG_G_SSE4A = 5'h0c,
		MFG_G_AVX = 5'h0d,
		MFG_G_XOP = 5'h0e,
		MFG_G_FMA = 5'h0f,
		MFG_G_FMA4 = 5'h10,
		MFG_G_FULL_SAVE = 5'h11,
		MFG_G_FULL_RESTORE = 5'h12,
		MFG_G_XSAVE = 5'h13,
		MFG_G_OPT_SAVE = 5'h14,
		MFG_G_XCR_WRITE = 5'h15,
		MFG_G_XCR_READ = 5'h16
	} mfg_grp_t;
	typedef enum logic [2:0] {
		MFG_F_NONE = 3'h0,
		MFG_F_INVALID_OPCODE = 3'h1,
		MFG_F_DEVICE_UNAVAIL = 3'h2,
		MFG_F_GEN_PROTECT = 3'h3,
		MFG_F_SIMD_FP = 3'h4
	} mfg_fault_t;
endpackage

// file: design/mfg_feature_rom.sv
// Feature query answer table of the media/x87 gate (combinational).
// Assumes the caller registers the outputs and gives an effective support vector.
`timescale 1ns/1ps
`include "mfg_defs.svh"
module mfg_feature_rom (
	input wire logic [31:0] leaf_i,
	input wire logic [31:0] subleaf_i,
	input wire logic [22:0] sup_i,
	input wire logic fast_save_i,
	input wire logic [63:0] mask_i,
	input wire logic [31:0] size_en_i,
	input wire logic [31:0] size_max_i,
	output logic [31:0] eax_o,
	output logic [31:0] ebx_o,
	output logic [31:0] ecx_o,
	output logic [31:0] edx_o
);
	import mfg_pkg::*;
	logic [31:0] edx_common;
	always_comb begin
		edx_common = '0;
		edx_common[`MFG_EDX_X87] = sup_i[MFG_G_X87];
		edx_common[`MFG_EDX_PKINT] = sup_i[MFG_G_PKINT];
		edx_common[`MFG_EDX_FULLSAVE] = sup_i[MFG_G_FULL_SAVE];
	end
	always_comb begin
		eax_o = '0;
		ebx_o = '0;
		ecx_o = '0;
		edx_o = '0;
		if (leaf_i == `MFG_LEAF_STD) begin
			edx_o = edx_common;
			edx_o[`MFG_STD_EDX_SSE1] = sup_i[MFG_G_SSE1];
			edx_o[`MFG_STD_EDX_SSE2] = sup_i[MFG_G_SSE2];
			ecx_o[`MFG_STD_ECX_SSE3] = sup_i[MFG_G_SSE3];
			ecx_o[`MFG_STD_ECX_SSSE3] = sup_i[MFG_G_SSSE3];
			ecx_o[`MFG_STD_ECX_SSE41] = sup_i[MFG_G_SSE41];
			ecx_o[`MFG_STD_ECX_SSE42] = sup_i[MFG_G_SSE42];
			ecx_o[`MFG_STD_ECX_FMA] = sup_i[MFG_G_FMA];
			ecx_o[`MFG_STD_ECX_AVX] = sup_i[MFG_G_AVX];
			ecx_o[`MFG_STD_ECX_XSAVE] = sup_i[MFG_G_XSAVE];
		end else if (leaf_i == `MFG_LEAF_EXT) begin
			edx_o = edx_common;
			ecx_o[`MFG_EXT_ECX_SSE4A] = sup_i[MFG_G_SSE4A];
			ecx_o[`MFG_EXT_ECX_XOP] = sup_i[MFG_G_XOP];
			ecx_o[`MFG_EXT_ECX_FMA4] = sup_i[MFG_G_FMA4];
			edx_o[`MFG_EXT_EDX_PKEXT] = sup_i[MFG_G_PKINT_EXT];
			edx_o[`MFG_EXT_EDX_V3DEXT] = sup_i[MFG_G_V3D_EXT];
			edx_o[`MFG_EXT_EDX_V3D] = sup_i[MFG_G_V3D];
			edx_o[`MFG_EXT_EDX_FASTSAVE] = fast_save_i;
		end else if (leaf_i == `MFG_LEAF_XST && sup_i[MFG_G_XSAVE]) begin
			if (subleaf_i == `MFG_SUB_ZERO) begin
				eax_o[`MFG_XCR_X87] = sup_i[MFG_G_X87];
				eax_o[`MFG_XCR_SSE] = sup_i[MFG_G_SSE1];
				eax_o[`MFG_XCR_YMM] = sup_i[MFG_G_AVX];
				ebx_o = size_en_i;
				ecx_o = size_max_i;
			end else if (subleaf_i == `MFG_SUB_ONE) begin
				eax_o[`MFG_XST1_EAX_OPTSAVE] = sup_i[MFG_G_OPT_SAVE];
			end
		end
		if (mask_i == 64'h0) begin
			ecx_o = ecx_o;
		end
	end
endmodule // mfg_feature_rom

// file: design/mfg_fault_gate.sv
// Media/x87 enable and fault gate: answers feature queries, holds the extended
// feature enable mask and decides the fault for each issued instruction.
// Assumes the core presents one request per cycle on its own clock; control
// register bits arrive as plain levels from core logic on the same clock.
// Notes on behaviour
// - Standard leaf EDX bits 25 and 26 report the two first SIMD generations.
// - Standard leaf ECX reports later SIMD, multiply-add, wide vectors, extended save.
// - Extended leaf reports SSE4A, extended ops, 4-operand madd, packed/3D ext, fast save.
// - Both leaves report x87, packed-integer and full-state save in EDX 0, 23, 24.
// - Leaf 0Dh subleaf 1 EAX bit 0 reports the optimized state save.
// - Instructions of unimplemented subsets raise the invalid-opcode fault.
// - Legacy SIMD runs only with full-save support set, else invalid-opcode.
// - Coprocessor emulation set makes legacy SIMD raise invalid-opcode.
// - Emulation set turns full-state save and restore into device-unavailable.
// - Emulation clear, monitor set, task switched: media, x87, wait fault unavailable.
// - Leaf 0Dh subleaf 0 EAX gives the supported state mask, full is 111b.
// - Extended SIMD support requires x87 and legacy SIMD support.
// - Control-register write and read work only with extended save enabled.
// - Control-register write is privileged and writes the feature enable mask.
// - Leaf 0Dh subleaf 0 EBX gives save-area bytes for currently enabled features.
// - Unmasked SIMD exception vectors to SIMD fault if handler ready, else invalid-opcode.
// - Masked SIMD exceptions take the default response, never a fault.
`timescale 1ns/1ps
`include "mfg_defs.svh"
module mfg_fault_gate #(
	parameter logic [22:0] SUPPORTED = 23'h7f_ffff,
	parameter logic FAST_SAVE = 1'b1,
	parameter logic [31:0] LEGACY_AREA_BYTES = 32'd576,
	parameter logic [31:0] WIDE_AREA_BYTES = 32'd256
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Control register bits and current privilege level
	input wire logic soft_fpu_trap_flag_i,
	input wire logic monitor_coproc_i,
	input wire logic task_switched_i,
	input wire logic os_full_save_support_i,
	input wire logic os_extended_save_enable_i,
	input wire logic os_simd_fault_handler_ready_i,
	input wire logic [1:0] cpl_i,
	// Instruction issue
	input wire logic issue_valid_i,
	input wire mfg_pkg::mfg_grp_t issue_grp_i,
	input wire logic [31:0] xcr_index_i,
	input wire logic [63:0] xcr_wdata_i,
	// SIMD floating-point exception report
	input wire logic simd_exc_valid_i,
	input wire logic simd_exc_unmasked_i,
	// Feature query
	input wire logic query_valid_i,
	input wire logic [31:0] query_leaf_i,
	input wire logic [31:0] query_subleaf_i,
	// Results
	output logic exec_ok_o,
	output logic fault_valid_o,
	output mfg_pkg::mfg_fault_t fault_code_o,
	output logic simd_default_o,
	output logic [63:0] feature_state_enable_mask_o,
	output logic [63:0] xcr_rdata_o,
	output logic query_done_o,
	output logic [31:0] query_eax_o,
	output logic [31:0] query_ebx_o,
	output logic [31:0] query_ecx_o,
	output logic [31:0] query_edx_o
);
	import mfg_pkg::*;

	logic [22:0] sup_eff;
	logic base_ok;
	logic [63:0] mask_q;
	logic [63:0] mask_d;
	logic [63:0] sup_mask;
	logic mask_we;
	logic [31:0] size_en;
	logic [31:0] size_max;
	logic [31:0] rom_eax;
	logic [31:0] rom_ebx;
	logic [31:0] rom_ecx;
	logic [31:0] rom_edx;
	logic is_legacy_simd;
	logic is_ext_simd;
	logic is_media_x87;
	logic grp_known;
	mfg_fault_t fault_d;
	logic accept_d;

	// Extended groups exist only on top of x87 and legacy SIMD
	assign base_ok = SUPPORTED[MFG_G_X87] & SUPPORTED[MFG_G_SSE1];

	genvar gi;
	generate
		for (gi = 0; gi < 23; gi++) begin : g_sup
			if (gi == MFG_G_AVX || gi == MFG_G_XOP || gi == MFG_G_FMA
					|| gi == MFG_G_FMA4) begin : g_ext
				assign sup_eff[gi] = SUPPORTED[gi] & base_ok;
			end else begin : g_plain
				assign sup_eff[gi] = SUPPORTED[gi];
			end
		end
	endgenerate

	always_comb begin
		sup_mask = '0;
		sup_mask[`MFG_XCR_X87] = sup_eff[MFG_G_X87];
		sup_mask[`MFG_XCR_SSE] = sup_eff[MFG_G_SSE1];
		sup_mask[`MFG_XCR_YMM] = sup_eff[MFG_G_AVX];
	end

	// Enabled save-area size follows the live enable mask; maximum size follows support
	always_comb begin
		size_en = LEGACY_AREA_BYTES;
		if (mask_q[`MFG_XCR_YMM]) begin
			size_en = LEGACY_AREA_BYTES + WIDE_AREA_BYTES;
		end
		size_max = LEGACY_AREA_BYTES;
		if (sup_mask[`MFG_XCR_YMM]) begin
			size_max = LEGACY_AREA_BYTES + WIDE_AREA_BYTES;
		end
	end

	mfg_feature_rom u_rom (
		.leaf_i(query_leaf_i),
		.subleaf_i(query_subleaf_i),
		.sup_i(sup_eff),
		.fast_save_i(FAST_SAVE),
		.mask_i(mask_q),
		.size_en_i(size_en),
		.size_max_i(size_max),
		.eax_o(rom_eax),
		.ebx_o(rom_ebx),
		.ecx_o(rom_ecx),
		.edx_o(rom_edx)
	);

	always_comb begin
		is_legacy_simd = 1'b0;
		is_ext_simd = 1'b0;
		grp_known = 1'b1;
		unique case (issue_grp_i)
			MFG_G_SSE1, MFG_G_SSE2, MFG_G_SSE3, MFG_G_SSSE3,
			MFG_G_SSE41, MFG_G_SSE42, MFG_G_SSE4A: begin
				is_legacy_simd = 1'b1;
			end
			MFG_G_AVX, MFG_G_XOP, MFG_G_FMA, MFG_G_FMA4: begin
				is_ext_simd = 1'b1;
			end
			MFG_G_X87, MFG_G_FPWAIT, MFG_G_PKINT, MFG_G_PKINT_EXT,
			MFG_G_V3D, MFG_G_V3D_EXT, MFG_G_FULL_SAVE, MFG_G_FULL_RESTORE,
			MFG_G_XSAVE, MFG_G_OPT_SAVE, MFG_G_XCR_WRITE, MFG_G_XCR_READ: begin
				grp_known = 1'b1;
			end
			default: begin
				grp_known = 1'b0;
			end
		endcase
		// Control-register access is not a media or x87 instruction
		is_media_x87 = grp_known && issue_grp_i != MFG_G_XCR_WRITE
			&& issue_grp_i != MFG_G_XCR_READ;
	end

	// Proposed mask must keep x87 and pair wide state with legacy SIMD
	always_comb begin
		mask_d = xcr_wdata_i;
		mask_we = 1'b0;
		if (issue_valid_i && !simd_exc_valid_i && issue_grp_i == MFG_G_XCR_WRITE
				&& fault_d == MFG_F_NONE) begin
			mask_we = 1'b1;
		end
	end

	// Fault priority: subset, emulation, enables, task switch, privilege, value
	always_comb begin
		fault_d = MFG_F_NONE;
		if (!grp_known || !sup_eff[issue_grp_i]) begin
			fault_d = MFG_F_INVALID_OPCODE;
		end else if (is_legacy_simd && soft_fpu_trap_flag_i) begin
			fault_d = MFG_F_INVALID_OPCODE;
		end else if (is_legacy_simd && !os_full_save_support_i) begin
			fault_d = MFG_F_INVALID_OPCODE;
		end else if ((issue_grp_i == MFG_G_FULL_SAVE || issue_grp_i == MFG_G_FULL_RESTORE)
				&& soft_fpu_trap_flag_i) begin
			fault_d = MFG_F_DEVICE_UNAVAIL;
		end else if ((is_ext_simd || issue_grp_i == MFG_G_XSAVE
				|| issue_grp_i == MFG_G_OPT_SAVE
				|| issue_grp_i == MFG_G_XCR_WRITE
				|| issue_grp_i == MFG_G_XCR_READ)
				&& !os_extended_save_enable_i) begin
			fault_d = MFG_F_INVALID_OPCODE;
		end else if (is_ext_simd && !(mask_q[`MFG_XCR_YMM] && mask_q[`MFG_XCR_SSE])) begin
			fault_d = MFG_F_INVALID_OPCODE;
		end else if (is_media_x87 && !soft_fpu_trap_flag_i && monitor_coproc_i
				&& task_switched_i) begin
			fault_d = MFG_F_DEVICE_UNAVAIL;
		end else if (issue_grp_i == MFG_G_XCR_WRITE && cpl_i != 2'h0) begin
			fault_d = MFG_F_GEN_PROTECT;
		end else if ((issue_grp_i == MFG_G_XCR_WRITE || issue_grp_i == MFG_G_XCR_READ)
				&& xcr_index_i != `MFG_EXTENDED_FEATURE_ENABLE_MASK_INDEX) begin
			fault_d = MFG_F_GEN_PROTECT;
		end else if (issue_grp_i == MFG_G_XCR_WRITE
				&& (!xcr_wdata_i[`MFG_XCR_X87]
				|| (xcr_wdata_i[`MFG_XCR_YMM] && !xcr_wdata_i[`MFG_XCR_SSE])
				|| (xcr_wdata_i & ~sup_mask) != 64'h0)) begin
			fault_d = MFG_F_GEN_PROTECT;
		end
		accept_d = issue_valid_i && fault_d == MFG_F_NONE;
	end

	// Enable mask; a refused write leaves it untouched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= `MFG_EXTENDED_FEATURE_ENABLE_MASK_RST;
		end else if (mask_we) begin
			mask_q <= mask_d;
		end
	end

	// Instruction and exception outcome; the exception belongs to an older
	// instruction so it takes the cycle and the issue is dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exec_ok_o <= 1'b0;
			fault_valid_o <= 1'b0;
			fault_code_o <= MFG_F_NONE;
			simd_default_o <= 1'b0;
		end else if (simd_exc_valid_i) begin
			exec_ok_o <= 1'b0;
			if (simd_exc_unmasked_i) begin
				fault_valid_o <= 1'b1;
				simd_default_o <= 1'b0;
				if (os_simd_fault_handler_ready_i) begin
					fault_code_o <= MFG_F_SIMD_FP;
				end else begin
					fault_code_o <= MFG_F_INVALID_OPCODE;
				end
			end else begin
				fault_valid_o <= 1'b0;
				fault_code_o <= MFG_F_NONE;
				simd_default_o <= 1'b1;
			end
		end else begin
			simd_default_o <= 1'b0;
			exec_ok_o <= accept_d;
			fault_valid_o <= issue_valid_i && fault_d != MFG_F_NONE;
			fault_code_o <= issue_valid_i ? fault_d : MFG_F_NONE;
		end
	end

	// Read data of the control-register read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xcr_rdata_o <= '0;
		end else if (accept_d && !simd_exc_valid_i && issue_grp_i == MFG_G_XCR_READ) begin
			xcr_rdata_o <= mask_q;
		end
	end

	assign feature_state_enable_mask_o = mask_q;

	// Query answers held until the next query
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			query_done_o <= 1'b0;
			query_eax_o <= '0;
			query_ebx_o <= '0;
			query_ecx_o <= '0;
			query_edx_o <= '0;
		end else begin
			query_done_o <= query_valid_i;
			if (query_valid_i) begin
				query_eax_o <= rom_eax;
				query_ebx_o <= rom_ebx;
				query_ecx_o <= rom_ecx;
				query_edx_o <= rom_edx;
			end
		end
	end

endmodule // mfg_fault_gate

// file: tb/mfg_fault_gate_sva.sv
// Checker of the media/x87 gate answers at the top-level ports.
// Assumes a bind to mfg_fault_gate with its default, all-supported parameters.
`timescale 1ns/1ps
module mfg_fault_gate_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_fpu_trap_flag_i,
	input wire logic monitor_coproc_i,
	input wire logic task_switched_i,
	input wire logic os_full_save_support_i,
	input wire logic os_extended_save_enable_i,
	input wire logic os_simd_fault_handler_ready_i,
	input wire logic issue_valid_i,
	input wire mfg_pkg::mfg_grp_t issue_grp_i,
	input wire logic [63:0] xcr_wdata_i,
	input wire logic simd_exc_valid_i,
	input wire logic simd_exc_unmasked_i,
	input wire logic query_valid_i,
	input wire logic exec_ok_o,
	input wire logic fault_valid_o,
	input wire mfg_pkg::mfg_fault_t fault_code_o,
	input wire logic simd_default_o,
	input wire logic [63:0] feature_state_enable_mask_o,
	input wire logic query_done_o
);
	import mfg_pkg::*;
	logic iss;
	// A same-cycle exception report drops the issue
	assign iss = issue_valid_i && !simd_exc_valid_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_query_answer: assert property (query_valid_i |=> query_done_o)
		else $error("query not answered next cycle");
	chk_one_answer: assert property (iss |=> exec_ok_o != fault_valid_o)
		else $error("issue without exactly one answer");
	chk_legacy_off: assert property (iss && issue_grp_i == MFG_G_SSE1
		&& !os_full_save_support_i |=> fault_valid_o && fault_code_o == MFG_F_INVALID_OPCODE)
		else $error("legacy simd ran without full save support");
	chk_save_emul: assert property (iss && soft_fpu_trap_flag_i
		&& issue_grp_i inside {MFG_G_FULL_SAVE, MFG_G_FULL_RESTORE}
		|=> fault_code_o == MFG_F_DEVICE_UNAVAIL)
		else $error("full save under emulation not unavailable");
	chk_lazy_switch: assert property (iss && !soft_fpu_trap_flag_i && monitor_coproc_i
		&& task_switched_i && issue_grp_i inside {MFG_G_X87, MFG_G_FPWAIT, MFG_G_PKINT}
		|=> fault_valid_o && fault_code_o == MFG_F_DEVICE_UNAVAIL)
		else $error("task switched did not trap");
	chk_xcr_gate: assert property (iss && !os_extended_save_enable_i
		&& issue_grp_i inside {MFG_G_XCR_WRITE, MFG_G_XCR_READ}
		|=> fault_code_o == MFG_F_INVALID_OPCODE)
		else $error("control write or read ran while disabled");
	chk_bad_write: assert property (iss && issue_grp_i == MFG_G_XCR_WRITE
		&& os_extended_save_enable_i && !xcr_wdata_i[0]
		|=> fault_code_o == MFG_F_GEN_PROTECT && $stable(feature_state_enable_mask_o))
		else $error("mask write without x87 bit accepted");
	chk_mask_source: assert property ($changed(feature_state_enable_mask_o)
		|-> $past(iss) && $past(issue_grp_i) == MFG_G_XCR_WRITE)
		else $error("mask changed without a control write");
	chk_simd_vector: assert property (simd_exc_valid_i && simd_exc_unmasked_i
		|=> fault_valid_o && fault_code_o == ($past(os_simd_fault_handler_ready_i)
		? MFG_F_SIMD_FP : MFG_F_INVALID_OPCODE))
		else $error("unmasked simd exception took wrong vector");
	chk_simd_masked: assert property (simd_exc_valid_i && !simd_exc_unmasked_i
		|=> simd_default_o && !fault_valid_o)
		else $error("masked simd exception faulted");
endmodule // mfg_fault_gate_sva
bind mfg_fault_gate mfg_fault_gate_sva u_sva (.clk_i, .rst_i, .soft_fpu_trap_flag_i,
	.monitor_coproc_i, .task_switched_i, .os_full_save_support_i, .os_extended_save_enable_i,
	.os_simd_fault_handler_ready_i, .issue_valid_i, .issue_grp_i, .xcr_wdata_i,
	.simd_exc_valid_i, .simd_exc_unmasked_i, .query_valid_i, .exec_ok_o, .fault_valid_o,
	.fault_code_o, .simd_default_o, .feature_state_enable_mask_o, .query_done_o);

// file: tb/tb_top.sv
// Self-checking bench of the media/x87 gate: queries, issue gating, mask writes.
// Assumes default gate parameters, so every instruction group is implemented.
`timescale 1ns/1ps
module tb_top;
	import mfg_pkg::*;
	logic clk_i, rst_i, emu, mon, tsw, fxs, xse, xfr, iv, sv, su, qv;
	logic [1:0] cpl;
	mfg_grp_t grp;
	logic [63:0] wd, mask_o, rdata_o;
	logic [31:0] leaf, sub, eax, ebx, ecx, edx;
	logic exec_ok_o, fault_valid_o, simd_default_o, query_done_o;
	mfg_fault_t fault_code_o;
	int miscompares, checks_done, cycles;
	mfg_fault_gate dut (.clk_i(clk_i), .rst_i(rst_i), .soft_fpu_trap_flag_i(emu),
		.monitor_coproc_i(mon), .task_switched_i(tsw), .os_full_save_support_i(fxs),
		.os_extended_save_enable_i(xse), .os_simd_fault_handler_ready_i(xfr), .cpl_i(cpl),
		.issue_valid_i(iv), .issue_grp_i(grp), .xcr_index_i(32'h0), .xcr_wdata_i(wd),
		.simd_exc_valid_i(sv), .simd_exc_unmasked_i(su), .query_valid_i(qv),
		.query_leaf_i(leaf), .query_subleaf_i(sub), .exec_ok_o(exec_ok_o),
		.fault_valid_o(fault_valid_o), .fault_code_o(fault_code_o),
		.simd_default_o(simd_default_o), .feature_state_enable_mask_o(mask_o),
		.xcr_rdata_o(rdata_o), .query_done_o(query_done_o), .query_eax_o(eax),
		.query_ebx_o(ebx), .query_ecx_o(ecx), .query_edx_o(edx));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Run is under two hundred cycles; the ceiling only catches a hang
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic ctl(input logic [5:0] v);
		@(posedge clk_i);
		{emu, mon, tsw, fxs, xse, xfr} <= v;
	endtask
	task automatic issue(input mfg_grp_t g, input mfg_fault_t exp);
		@(posedge clk_i);
		iv <= 1'b1;
		grp <= g;
		@(posedge clk_i);
		iv <= 1'b0;
		#1;
		check("fault_code", exp, fault_code_o);
		check("exec_ok", exp == MFG_F_NONE, exec_ok_o);
		check("fault_valid", exp != MFG_F_NONE, fault_valid_o);
	endtask
	task automatic query(input logic [31:0] l, input logic [31:0] s);
		@(posedge clk_i);
		qv <= 1'b1;
		leaf <= l;
		sub <= s;
		@(posedge clk_i);
		qv <= 1'b0;
		#1;
		check("query_done", 64'h1, query_done_o);
	endtask
	task automatic simd(input logic unm, input mfg_fault_t exp, input logic dflt);
		@(posedge clk_i);
		sv <= 1'b1;
		su <= unm;
		@(posedge clk_i);
		sv <= 1'b0;
		#1;
		check("simd_code", exp, fault_code_o);
		check("simd_default", dflt, simd_default_o);
		check("simd_fault", exp != MFG_F_NONE, fault_valid_o);
	endtask
	initial begin
		{emu, mon, tsw, fxs, xse, xfr} = 6'b010000;
		rst_i = 1'b1;
		cpl = 2'h0;
		{iv, sv, su, qv} = 4'h0;
		grp = MFG_G_X87;
		wd = 64'h0;
		leaf = 32'h0;
		sub = 32'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check("mask_reset", 64'h1, mask_o);
		query(32'h1, 32'h0);
		check("std_edx", 32'h0780_0001, edx);
		check("std_ecx", 32'h1418_1201, ecx);
		query(32'h8000_0001, 32'h0);
		check("ext_edx", 32'hc3c0_0001, edx);
		check("ext_ecx", 32'h0001_0840, ecx);
		query(32'hd, 32'h0);
		check("state_mask", 32'h7, eax);
		check("area_x87", 32'h240, ebx);
		query(32'hd, 32'h1);
		check("opt_save", 1'b1, eax[0]);
		$display("test feature_query done");
		for (int g = 6; g <= 12; g++) issue(mfg_grp_t'(g), MFG_F_INVALID_OPCODE);
		ctl(6'b010100);
		wd = 64'h7;
		issue(MFG_G_XCR_WRITE, MFG_F_INVALID_OPCODE);
		issue(MFG_G_XCR_READ, MFG_F_INVALID_OPCODE);
		ctl(6'b010110);
		cpl = 2'h3;
		issue(MFG_G_XCR_WRITE, MFG_F_GEN_PROTECT);
		cpl = 2'h0;
		wd = 64'h6;
		issue(MFG_G_XCR_WRITE, MFG_F_GEN_PROTECT);
		wd = 64'h5;
		issue(MFG_G_XCR_WRITE, MFG_F_GEN_PROTECT);
		check("mask_kept", 64'h1, mask_o);
		wd = 64'h3;
		issue(MFG_G_XCR_WRITE, MFG_F_NONE);
		query(32'hd, 32'h0);
		check("area_sse", 32'h240, ebx);
		wd = 64'h7;
		issue(MFG_G_XCR_WRITE, MFG_F_NONE);
		check("mask_full", 64'h7, mask_o);
		issue(MFG_G_XCR_READ, MFG_F_NONE);
		check("xcr_read", 64'h7, rdata_o);
		query(32'hd, 32'h0);
		check("area_wide", 32'h340, ebx);
		$display("test enable_mask done");
		for (int g = 0; g <= 22; g++) issue(mfg_grp_t'(g), MFG_F_NONE);
		issue(mfg_grp_t'(5'h17), MFG_F_INVALID_OPCODE);
		ctl(6'b110110);
		issue(MFG_G_SSE1, MFG_F_INVALID_OPCODE);
		issue(MFG_G_FULL_SAVE, MFG_F_DEVICE_UNAVAIL);
		issue(MFG_G_FULL_RESTORE, MFG_F_DEVICE_UNAVAIL);
		ctl(6'b011110);
		for (int g = 0; g <= 20; g++) issue(mfg_grp_t'(g), MFG_F_DEVICE_UNAVAIL);
		$display("test issue_gating done");
		ctl(6'b010111);
		simd(1'b1, MFG_F_SIMD_FP, 1'b0);
		simd(1'b0, MFG_F_NONE, 1'b1);
		ctl(6'b010110);
		simd(1'b1, MFG_F_INVALID_OPCODE, 1'b0);
		simd(1'b0, MFG_F_NONE, 1'b1);
		$display("test simd_exception done");
		give_verdict();
	end
endmodule // tb_top
